// >>> pkg/mdd_defs.svh
`ifndef MDD_DEFS_SVH
`define MDD_DEFS_SVH

// ==========================================================
// opcode patterns
`define MDD_OPC_GRP_MULDIV  7'b1111011
`define MDD_OPC_MUL_IMM     8'b01101001
`define MDD_OPC_MUL_IMM_MSK 8'b11111101
`define MDD_OPC_ADJ_MUL     8'hd4
`define MDD_OPC_ADJ_DIV     8'hd5
`define MDD_ADJ_SECOND      8'h0a
`define MDD_OPC_SEXT_BW     8'h98
`define MDD_OPC_SEXT_WD     8'h99
`define MDD_OPC_SHIFT_ONE   7'b1101000
`define MDD_OPC_SHIFT_CNT   7'b1101001
`define MDD_OPC_SHIFT_IMM   7'b1100000
`define MDD_OPC_AND         6'b001000
`define MDD_OPC_OR          6'b000010
`define MDD_OPC_TEST_RM     7'b1000010
`define MDD_OPC_TEST_ACC    7'b1010100
`define MDD_REG_TEST_IMM    3'b000
`define MDD_REG_SMUL        3'b101
`define MDD_REG_UDIV        3'b110
`define MDD_REG_SDIV        3'b111
`define MDD_MOD_REGISTER    2'b11

// ==========================================================
// cycle counts: register byte, register word, memory byte, memory word
`define MDD_CNT_W           10
`define MDD_C_SMUL_RB       10'd25
`define MDD_C_SMUL_RW       10'd34
`define MDD_C_SMUL_MB       10'd31
`define MDD_C_SMUL_MW       10'd40
`define MDD_C_SMUL_SPAN     4'h3
`define MDD_C_SMULI_R       10'd22
`define MDD_C_SMULI_M       10'd29
`define MDD_C_UDIV_RB       10'd29
`define MDD_C_UDIV_RW       10'd38
`define MDD_C_UDIV_MB       10'd35
`define MDD_C_UDIV_MW       10'd44
`define MDD_C_SDIV_RB       10'd44
`define MDD_C_SDIV_RW       10'd53
`define MDD_C_SDIV_MB       10'd50
`define MDD_C_SDIV_MW       10'd59
`define MDD_C_SDIV_SPAN     4'h8
`define MDD_C_ADJ_MUL       10'd19
`define MDD_C_ADJ_DIV       10'd15
`define MDD_C_SEXT_BW       10'd2
`define MDD_C_SEXT_WD       10'd4
`define MDD_C_SHIFT1_R      10'd2
`define MDD_C_SHIFT1_M      10'd15
`define MDD_C_SHIFTN_R      10'd5
`define MDD_C_SHIFTN_M      10'd17
`define MDD_C_LOGIC_R       10'd3
`define MDD_C_LOGIC_M       10'd10
`define MDD_C_TESTI_R       10'd4
`define MDD_C_TESTA_B       10'd3
`define MDD_C_TESTA_W       10'd4
`define MDD_C_WORD_MEM      10'd4

`endif

// >>> pkg/mdd_pkg.sv
package mdd_pkg;

  // ==========================================================
  // types
  typedef enum logic [4:0] {
    OP_NONE, OP_GROUP, OP_SMUL, OP_SMUL_IMM, OP_UDIV, OP_SDIV,
    OP_ADJ_MUL, OP_ADJ_DIV, OP_SEXT_BW, OP_SEXT_WD,
    OP_SHIFT_ONE, OP_SHIFT_CNT, OP_SHIFT_IMM,
    OP_AND, OP_OR, OP_TEST_RM, OP_TEST_IMM, OP_TEST_ACC
  } mdd_op_t;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODRM, ST_SECOND, ST_IMM, ST_EXEC
  } mdd_state_t;

  typedef struct packed {
    mdd_op_t     op;
    logic        wide;
    logic        dir;
    logic        mem;
    logic        writes;
    logic [1:0]  mode;
    logic [2:0]  reg_f;
    logic [2:0]  rm;
    logic [15:0] imm;
  } mdd_instr_t;

endpackage : mdd_pkg

// >>> test/mdd_decode_tb.sv
`timescale 1ns/1ps

module mdd_decode_tb;
  logic                clk_i;
  logic                resetn_i;
  logic                byte_valid;
  logic [7:0]          byte_d;
  logic                byte_ready;
  logic [7:0]          shift_count_i;
  logic [3:0]          op_extra_i;
  logic [3:0]          gap;
  mdd_pkg::mdd_instr_t instr;
  logic                busy;
  logic                done;
  logic                illegal;
  int                  n_fail;
  int                  check_count;

  always #10 clk_i = ~clk_i;

  mdd_decode mdd_decode_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .byte_valid_i(byte_valid), .byte_i(byte_d),
    .byte_ready_o(byte_ready), .shift_count_i(shift_count_i), .op_extra_i(op_extra_i),
    .instr_o(instr), .busy_o(busy), .done_o(done), .illegal_o(illegal));

  mdd_fetch_model mdd_fetch_model_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .byte_ready_i(byte_ready), .gap_i(gap),
    .byte_valid_o(byte_valid), .byte_o(byte_d));

  // ==========================================================
  // checking and closing
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic timeout();
    n_fail++;
    report_and_stop();
  endtask : timeout

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic set_in(input logic [3:0] ex, input logic [7:0] sc, input logic [3:0] g);
    @(posedge clk_i);
    op_extra_i    <= ex;
    shift_count_i <= sc;
    gap           <= g;
    #1;
  endtask : set_in

  // bytes are given first byte leftmost; busy length is counted between settled samples
  task automatic run(input int nb, input logic [31:0] bytes, input int n_exp,
                     input mdd_pkg::mdd_op_t op_exp, input logic wr_exp);
    int n;
    int t;
    n = 0;
    t = 0;
    for (int i = 0; i < nb; i++) begin
      mdd_fetch_model_i.push(bytes[31-8*i -: 8]);
    end
    while (busy !== 1'b1) begin
      @(posedge clk_i);
      #1;
      t++;
      if (t > 100) timeout();
    end
    check("ready_busy", 32'(byte_ready), 32'h0);
    while (busy === 1'b1) begin
      n++;
      @(posedge clk_i);
      #1;
      if (n > 200) timeout();
    end
    check("cycles", 32'(n), 32'(n_exp));
    check("done", 32'(done), 32'h1);
    check("op", 32'(instr.op), 32'(op_exp));
    check("writes", 32'(instr.writes), 32'(wr_exp));
    check("illegal", 32'(illegal), 32'h0);
  endtask : run

  task automatic bad(input int nb, input logic [31:0] bytes);
    int t;
    t = 0;
    for (int i = 0; i < nb; i++) begin
      mdd_fetch_model_i.push(bytes[31-8*i -: 8]);
    end
    while (illegal !== 1'b1) begin
      @(posedge clk_i);
      #1;
      t++;
      if (t > 50) timeout();
    end
    check("busy_on_illegal", 32'(busy), 32'h0);
  endtask : bad

  // ==========================================================
  // scenarios
  task automatic t_sext_adjust();
    run(1, 32'h9800_0000, 2, mdd_pkg::OP_SEXT_BW, 1'b1);
    run(1, 32'h9900_0000, 4, mdd_pkg::OP_SEXT_WD, 1'b1);
    run(2, 32'hd40a_0000, 19, mdd_pkg::OP_ADJ_MUL, 1'b1);
    run(2, 32'hd50a_0000, 15, mdd_pkg::OP_ADJ_DIV, 1'b1);
    bad(2, 32'hd40b_0000);
  endtask : t_sext_adjust

  task automatic t_muldiv();
    run(2, 32'hf6e8_0000, 25, mdd_pkg::OP_SMUL, 1'b1);
    run(2, 32'hf7e8_0000, 34, mdd_pkg::OP_SMUL, 1'b1);
    set_in(4'h3, 8'h00, 4'h0);
    run(2, 32'hf6e8_0000, 28, mdd_pkg::OP_SMUL, 1'b1);
    run(2, 32'hf728_0000, 47, mdd_pkg::OP_SMUL, 1'b1);
    set_in(4'h0, 8'h00, 4'h0);
    run(2, 32'hf6f0_0000, 29, mdd_pkg::OP_UDIV, 1'b1);
    run(2, 32'hf7f0_0000, 38, mdd_pkg::OP_UDIV, 1'b1);
    run(2, 32'hf630_0000, 35, mdd_pkg::OP_UDIV, 1'b1);
    run(2, 32'hf730_0000, 48, mdd_pkg::OP_UDIV, 1'b1);
    set_in(4'h8, 8'h00, 4'h0);
    run(2, 32'hf6f8_0000, 52, mdd_pkg::OP_SDIV, 1'b1);
    set_in(4'hf, 8'h00, 4'h0);
    run(2, 32'hf738_0000, 71, mdd_pkg::OP_SDIV, 1'b1);
    set_in(4'h0, 8'h00, 4'h0);
    bad(2, 32'hf6c8_0000);
  endtask : t_muldiv

  task automatic t_imm_mul();
    run(3, 32'h6bc0_0500, 22, mdd_pkg::OP_SMUL_IMM, 1'b1);
    check("imm", 32'(instr.imm), 32'h0005);
    check("wide", 32'(instr.wide), 32'h1);
    run(3, 32'h6bc0_8500, 22, mdd_pkg::OP_SMUL_IMM, 1'b1);
    check("imm", 32'(instr.imm), 32'hff85);
    run(4, 32'h6900_3412, 33, mdd_pkg::OP_SMUL_IMM, 1'b1);
    check("imm", 32'(instr.imm), 32'h1234);
  endtask : t_imm_mul

  task automatic t_shift();
    for (int tt = 0; tt < 8; tt++) begin
      run(2, {8'hd0, 2'b11, 3'(tt), 19'h0}, 2, mdd_pkg::OP_SHIFT_ONE, 1'b1);
      check("reg_f", 32'(instr.reg_f), 32'(tt));
    end
    run(2, 32'hd120_0000, 19, mdd_pkg::OP_SHIFT_ONE, 1'b1);
    set_in(4'h0, 8'h05, 4'h0);
    run(2, 32'hd2e8_0000, 10, mdd_pkg::OP_SHIFT_CNT, 1'b1);
    set_in(4'h0, 8'h00, 4'h0);
    run(3, 32'hc0e0_0700, 12, mdd_pkg::OP_SHIFT_IMM, 1'b1);
    check("count", 32'(instr.imm[7:0]), 32'h07);
    run(3, 32'hc120_0300, 24, mdd_pkg::OP_SHIFT_IMM, 1'b1);
  endtask : t_shift

  // the fetch side stalls between bytes here
  task automatic t_logic();
    set_in(4'h0, 8'h00, 4'h3);
    run(2, 32'h20c1_0000, 3, mdd_pkg::OP_AND, 1'b1);
    check("dir", 32'(instr.dir), 32'h0);
    check("rm", 32'(instr.rm), 32'h1);
    run(2, 32'h2300_0000, 14, mdd_pkg::OP_AND, 1'b1);
    check("dir", 32'(instr.dir), 32'h1);
    check("mem", 32'(instr.mem), 32'h1);
    run(2, 32'h08c1_0000, 3, mdd_pkg::OP_OR, 1'b1);
    run(2, 32'h0b00_0000, 14, mdd_pkg::OP_OR, 1'b1);
    run(2, 32'h84c1_0000, 3, mdd_pkg::OP_TEST_RM, 1'b0);
    run(2, 32'h8500_0000, 14, mdd_pkg::OP_TEST_RM, 1'b0);
    run(3, 32'hf6c0_5500, 4, mdd_pkg::OP_TEST_IMM, 1'b0);
    run(4, 32'hf700_3412, 14, mdd_pkg::OP_TEST_IMM, 1'b0);
    check("imm", 32'(instr.imm), 32'h1234);
    run(2, 32'ha855_0000, 3, mdd_pkg::OP_TEST_ACC, 1'b0);
    run(3, 32'ha934_1200, 4, mdd_pkg::OP_TEST_ACC, 1'b0);
    check("imm", 32'(instr.imm), 32'h1234);
  endtask : t_logic

  // reset cuts a long divide; the decoder must come back idle and ready
  task automatic t_reset_mid();
    int t;
    t = 0;
    set_in(4'hf, 8'h00, 4'h0);
    mdd_fetch_model_i.push(8'hf7);
    mdd_fetch_model_i.push(8'h38);
    while (busy !== 1'b1) begin
      @(posedge clk_i);
      #1;
      t++;
      if (t > 100) timeout();
    end
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b0;
    #1;
    check("busy_in_reset", 32'(busy), 32'h0);
    check("done_in_reset", 32'(done), 32'h0);
    check("ready_in_reset", 32'(byte_ready), 32'h0);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    set_in(4'h0, 8'h00, 4'h0);
    check("ready_after_reset", 32'(byte_ready), 32'h1);
    check("busy_after_reset", 32'(busy), 32'h0);
    run(1, 32'h9800_0000, 2, mdd_pkg::OP_SEXT_BW, 1'b1);
  endtask : t_reset_mid

  // ==========================================================
  // main sequence
  initial begin
    clk_i         = 1'b0;
    resetn_i      = 1'b0;
    op_extra_i    = 4'h0;
    shift_count_i = 8'h00;
    gap           = 4'h0;
    n_fail        = 0;
    check_count   = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    t_sext_adjust();
    t_muldiv();
    t_imm_mul();
    t_shift();
    t_logic();
    t_reset_mid();
    report_and_stop();
  end
endmodule : mdd_decode_tb

// >>> test/mdd_fetch_model.sv
`timescale 1ns/1ps

module mdd_fetch_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // byte stream towards the decoder
  input  wire logic       byte_ready_i,
  input  wire logic [3:0] gap_i,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);
  logic [7:0] queue_q[$];
  int         idle_cnt;

  task automatic push(input logic [7:0] b);
    queue_q.push_back(b);
  endtask : push

  // ==========================================================
  // offer bytes in order, each held until the decoder takes it
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_valid_o <= 1'b0;
      byte_o       <= 8'h00;
      idle_cnt     = 0;
    end else if (!(byte_valid_o && !byte_ready_i)) begin
      if (idle_cnt < int'(gap_i) || queue_q.size() == 0) begin
        // lines wander while idle so a stale byte is never taken for a fresh one
        byte_valid_o <= 1'b0;
        byte_o       <= ~byte_o;
        idle_cnt     = idle_cnt + 1;
      end else begin
        byte_valid_o <= 1'b1;
        byte_o       <= queue_q.pop_front();
        idle_cnt     = 0;
      end
    end
  end
endmodule : mdd_fetch_model

// >>> verilog/mdd_cycle_timer.sv
`timescale 1ns/1ps
`include "mdd_defs.svh"

module mdd_cycle_timer (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  // control
  input  wire logic                    load_i,
  input  wire logic [`MDD_CNT_W-1:0]   load_val_i,
  output logic                         expire_o
);

  logic [`MDD_CNT_W-1:0] cnt_r;
  logic [`MDD_CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = load_val_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - `MDD_CNT_W'd1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // expires in the last cycle of the loaded count
  assign expire_o = (cnt_r == `MDD_CNT_W'd1);

endmodule : mdd_cycle_timer

// >>> verilog/mdd_decode.sv
`timescale 1ns/1ps
`include "mdd_defs.svh"

module mdd_decode (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // instruction byte stream from the fetch unit
  input  wire logic               byte_valid_i,
  input  wire logic [7:0]         byte_i,
  output logic                    byte_ready_o,
  // operand-dependent figures from the datapath
  input  wire logic [7:0]         shift_count_i,
  input  wire logic [3:0]         op_extra_i,
  // decoded instruction and sequencing
  output mdd_pkg::mdd_instr_t     instr_o,
  output logic                    busy_o,
  output logic                    done_o,
  output logic                    illegal_o
);

  // ==========================================================
  // decode helpers
  function automatic mdd_pkg::mdd_op_t first_class(input logic [7:0] b);
    first_class = mdd_pkg::OP_NONE;
    if (b[7:1] == `MDD_OPC_GRP_MULDIV)                             first_class = mdd_pkg::OP_GROUP;
    else if ((b & `MDD_OPC_MUL_IMM_MSK) == `MDD_OPC_MUL_IMM)       first_class = mdd_pkg::OP_SMUL_IMM;
    else if (b == `MDD_OPC_ADJ_MUL)                                first_class = mdd_pkg::OP_ADJ_MUL;
    else if (b == `MDD_OPC_ADJ_DIV)                                first_class = mdd_pkg::OP_ADJ_DIV;
    else if (b == `MDD_OPC_SEXT_BW)                                first_class = mdd_pkg::OP_SEXT_BW;
    else if (b == `MDD_OPC_SEXT_WD)                                first_class = mdd_pkg::OP_SEXT_WD;
    else if (b[7:1] == `MDD_OPC_SHIFT_ONE)                         first_class = mdd_pkg::OP_SHIFT_ONE;
    else if (b[7:1] == `MDD_OPC_SHIFT_CNT)                         first_class = mdd_pkg::OP_SHIFT_CNT;
    else if (b[7:1] == `MDD_OPC_SHIFT_IMM)                         first_class = mdd_pkg::OP_SHIFT_IMM;
    else if (b[7:2] == `MDD_OPC_AND)                               first_class = mdd_pkg::OP_AND;
    else if (b[7:2] == `MDD_OPC_OR)                                first_class = mdd_pkg::OP_OR;
    else if (b[7:1] == `MDD_OPC_TEST_RM)                           first_class = mdd_pkg::OP_TEST_RM;
    else if (b[7:1] == `MDD_OPC_TEST_ACC)                          first_class = mdd_pkg::OP_TEST_ACC;
  endfunction : first_class

  function automatic logic [3:0] clamp(input logic [3:0] x, input logic [3:0] lim);
    clamp = (x > lim) ? lim : x;
  endfunction : clamp

  function automatic logic [9:0] pick4(input logic m, input logic w,
                                       input logic [9:0] rb, input logic [9:0] rw,
                                       input logic [9:0] mb, input logic [9:0] mw);
    pick4 = m ? (w ? mw : mb) : (w ? rw : rb);
  endfunction : pick4

  function automatic logic [9:0] cycles(input mdd_pkg::mdd_instr_t i,
                                        input logic [7:0] n, input logic [3:0] ex);
    logic [9:0] c;
    c = '0;
    case (i.op)
      mdd_pkg::OP_SMUL:      c = pick4(i.mem, i.wide, `MDD_C_SMUL_RB, `MDD_C_SMUL_RW,
                                       `MDD_C_SMUL_MB, `MDD_C_SMUL_MW)
                                 + {6'h00, clamp(ex, `MDD_C_SMUL_SPAN)};
      mdd_pkg::OP_SMUL_IMM:  c = (i.mem ? `MDD_C_SMULI_M : `MDD_C_SMULI_R)
                                 + {6'h00, clamp(ex, `MDD_C_SMUL_SPAN)};
      mdd_pkg::OP_UDIV:      c = pick4(i.mem, i.wide, `MDD_C_UDIV_RB, `MDD_C_UDIV_RW,
                                       `MDD_C_UDIV_MB, `MDD_C_UDIV_MW);
      mdd_pkg::OP_SDIV:      c = pick4(i.mem, i.wide, `MDD_C_SDIV_RB, `MDD_C_SDIV_RW,
                                       `MDD_C_SDIV_MB, `MDD_C_SDIV_MW)
                                 + {6'h00, clamp(ex, `MDD_C_SDIV_SPAN)};
      mdd_pkg::OP_ADJ_MUL:   c = `MDD_C_ADJ_MUL;
      mdd_pkg::OP_ADJ_DIV:   c = `MDD_C_ADJ_DIV;
      mdd_pkg::OP_SEXT_BW:   c = `MDD_C_SEXT_BW;
      mdd_pkg::OP_SEXT_WD:   c = `MDD_C_SEXT_WD;
      mdd_pkg::OP_SHIFT_ONE: c = i.mem ? `MDD_C_SHIFT1_M : `MDD_C_SHIFT1_R;
      mdd_pkg::OP_SHIFT_CNT,
      mdd_pkg::OP_SHIFT_IMM: c = (i.mem ? `MDD_C_SHIFTN_M : `MDD_C_SHIFTN_R) + {2'b00, n};
      mdd_pkg::OP_AND,
      mdd_pkg::OP_OR,
      mdd_pkg::OP_TEST_RM:   c = i.mem ? `MDD_C_LOGIC_M : `MDD_C_LOGIC_R;
      mdd_pkg::OP_TEST_IMM:  c = i.mem ? `MDD_C_LOGIC_M : `MDD_C_TESTI_R;
      mdd_pkg::OP_TEST_ACC:  c = i.wide ? `MDD_C_TESTA_W : `MDD_C_TESTA_B;
      default:               c = `MDD_C_SEXT_BW;
    endcase
    if (i.mem && i.wide) begin
      c = c + `MDD_C_WORD_MEM;
    end
    cycles = c;
  endfunction : cycles

  // ==========================================================
  // decode state
  mdd_pkg::mdd_state_t state_r, state_nxt;
  mdd_pkg::mdd_instr_t instr_r, instr_nxt;
  logic [1:0]          imm_left_r, imm_left_nxt;
  logic                imm_got_r, imm_got_nxt;
  logic                done_nxt, illegal_nxt;
  logic                finish;
  logic                load;
  logic [9:0]          load_val;
  logic [9:0]          run_len_r, run_len_nxt;
  logic [7:0]          n_sel;
  logic                take;
  logic                expire;

  // the ready flop follows the next state, so take matches what the source saw
  assign take = byte_valid_i && byte_ready_o;

  always_comb begin
    state_nxt    = state_r;
    instr_nxt    = instr_r;
    imm_left_nxt = imm_left_r;
    imm_got_nxt  = imm_got_r;
    done_nxt     = 1'b0;
    illegal_nxt  = 1'b0;
    finish       = 1'b0;
    n_sel        = shift_count_i;
    run_len_nxt  = (state_r == mdd_pkg::ST_EXEC) ? run_len_r + 10'h001 : run_len_r;
    case (state_r)
      mdd_pkg::ST_OPCODE: if (take) begin
        instr_nxt      = '0;
        instr_nxt.op   = first_class(byte_i);
        instr_nxt.wide = byte_i[0];
        instr_nxt.dir  = byte_i[1];
        imm_got_nxt    = 1'b0;
        imm_left_nxt   = 2'h0;
        case (first_class(byte_i))
          mdd_pkg::OP_NONE: illegal_nxt = 1'b1;
          mdd_pkg::OP_SEXT_BW,
          mdd_pkg::OP_SEXT_WD: finish = 1'b1;
          mdd_pkg::OP_ADJ_MUL,
          mdd_pkg::OP_ADJ_DIV: state_nxt = mdd_pkg::ST_SECOND;
          mdd_pkg::OP_TEST_ACC: begin
            imm_left_nxt = byte_i[0] ? 2'h2 : 2'h1;
            state_nxt    = mdd_pkg::ST_IMM;
          end
          mdd_pkg::OP_SMUL_IMM: begin
            instr_nxt.wide = 1'b1;
            state_nxt      = mdd_pkg::ST_MODRM;
          end
          default: state_nxt = mdd_pkg::ST_MODRM;
        endcase
      end
      mdd_pkg::ST_MODRM: if (take) begin
        instr_nxt.mode  = byte_i[7:6];
        instr_nxt.reg_f = byte_i[5:3];
        instr_nxt.rm    = byte_i[2:0];
        instr_nxt.mem   = (byte_i[7:6] != `MDD_MOD_REGISTER);
        if (instr_r.op == mdd_pkg::OP_GROUP) begin
          case (byte_i[5:3])
            `MDD_REG_TEST_IMM: instr_nxt.op = mdd_pkg::OP_TEST_IMM;
            `MDD_REG_SMUL:     instr_nxt.op = mdd_pkg::OP_SMUL;
            `MDD_REG_UDIV:     instr_nxt.op = mdd_pkg::OP_UDIV;
            `MDD_REG_SDIV:     instr_nxt.op = mdd_pkg::OP_SDIV;
            default:           instr_nxt.op = mdd_pkg::OP_NONE;
          endcase
        end
        case (instr_nxt.op)
          mdd_pkg::OP_NONE: begin
            illegal_nxt = 1'b1;
            state_nxt   = mdd_pkg::ST_OPCODE;
          end
          mdd_pkg::OP_TEST_IMM: begin
            imm_left_nxt = instr_r.wide ? 2'h2 : 2'h1;
            state_nxt    = mdd_pkg::ST_IMM;
          end
          mdd_pkg::OP_SMUL_IMM: begin
            imm_left_nxt = instr_r.dir ? 2'h1 : 2'h2;
            state_nxt    = mdd_pkg::ST_IMM;
          end
          mdd_pkg::OP_SHIFT_IMM: begin
            imm_left_nxt = 2'h1;
            state_nxt    = mdd_pkg::ST_IMM;
          end
          default: finish = 1'b1;
        endcase
      end
      mdd_pkg::ST_SECOND: if (take) begin
        finish      = (byte_i == `MDD_ADJ_SECOND);
        illegal_nxt = !finish;
        state_nxt   = mdd_pkg::ST_OPCODE;
      end
      mdd_pkg::ST_IMM: if (take) begin
        // low byte arrives first
        instr_nxt.imm[{imm_got_r, 3'b000} +: 8] = byte_i;
        imm_got_nxt  = 1'b1;
        imm_left_nxt = imm_left_r - 2'h1;
        n_sel        = byte_i;
        if (imm_left_r == 2'h1) begin
          finish = 1'b1;
          if (instr_r.op == mdd_pkg::OP_SMUL_IMM && instr_r.dir) begin
            instr_nxt.imm[15:8] = {8{byte_i[7]}};
          end
        end
      end
      mdd_pkg::ST_EXEC: if (expire) begin
        state_nxt = mdd_pkg::ST_OPCODE;
        done_nxt  = 1'b1;
      end
      default: state_nxt = mdd_pkg::ST_OPCODE;
    endcase
    if (finish) begin
      // tests only touch flags; everything else writes back
      instr_nxt.writes = !(instr_nxt.op == mdd_pkg::OP_TEST_RM ||
                           instr_nxt.op == mdd_pkg::OP_TEST_IMM ||
                           instr_nxt.op == mdd_pkg::OP_TEST_ACC);
      state_nxt   = mdd_pkg::ST_EXEC;
      run_len_nxt = 10'h000;
    end
    load     = finish;
    load_val = cycles(instr_nxt, n_sel, op_extra_i);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r      <= mdd_pkg::ST_OPCODE;
      instr_r      <= '0;
      imm_left_r   <= 2'h0;
      imm_got_r    <= 1'b0;
      run_len_r    <= 10'h000;
      byte_ready_o <= 1'b0;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      illegal_o    <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      instr_r      <= instr_nxt;
      imm_left_r   <= imm_left_nxt;
      imm_got_r    <= imm_got_nxt;
      run_len_r    <= run_len_nxt;
      byte_ready_o <= (state_nxt != mdd_pkg::ST_EXEC);
      busy_o       <= (state_nxt == mdd_pkg::ST_EXEC);
      done_o       <= done_nxt;
      illegal_o    <= illegal_nxt;
    end
  end

  assign instr_o = instr_r;

  mdd_cycle_timer mdd_cycle_timer_i (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .load_i     (load),
    .load_val_i (load_val),
    .expire_o   (expire)
  );

  // ==========================================================
  // checks
  a_sext_bw_time: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == mdd_pkg::ST_OPCODE && take && byte_i == `MDD_OPC_SEXT_BW)
    |=> busy_o [*2] ##1 (done_o && !busy_o)) else $error("byte sign extend length");
  a_sext_wd_time: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_r == mdd_pkg::ST_OPCODE && take && byte_i == `MDD_OPC_SEXT_WD)
    |=> busy_o [*4] ##1 (done_o && !busy_o)) else $error("word sign extend length");
  a_adj_mul_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_ADJ_MUL) |-> run_len_r == `MDD_C_ADJ_MUL)
    else $error("adjust after multiply length");
  a_adj_div_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_ADJ_DIV) |-> run_len_r == `MDD_C_ADJ_DIV)
    else $error("adjust before divide length");
  a_udiv_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_UDIV) |-> run_len_r ==
    pick4(instr_o.mem, instr_o.wide, `MDD_C_UDIV_RB, `MDD_C_UDIV_RW, `MDD_C_UDIV_MB,
          `MDD_C_UDIV_MW + `MDD_C_WORD_MEM)) else $error("unsigned divide length");
  a_sdiv_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_SDIV && !instr_o.mem && !instr_o.wide)
    |-> run_len_r >= `MDD_C_SDIV_RB && run_len_r <= `MDD_C_SDIV_RB + 10'd8)
    else $error("signed divide length");
  a_smul_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_SMUL && !instr_o.mem && instr_o.wide)
    |-> run_len_r >= `MDD_C_SMUL_RW && run_len_r <= `MDD_C_SMUL_RW + 10'd3)
    else $error("signed multiply length");
  a_test_no_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (busy_o && (instr_o.op == mdd_pkg::OP_TEST_RM || instr_o.op == mdd_pkg::OP_TEST_ACC ||
                instr_o.op == mdd_pkg::OP_TEST_IMM))
    |-> !instr_o.writes) else $error("test must not write");
  a_logic_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_AND)
    |-> run_len_r == (instr_o.mem ? `MDD_C_LOGIC_M + (instr_o.wide ? `MDD_C_WORD_MEM : 10'd0)
                                  : `MDD_C_LOGIC_R)) else $error("logic op length");
  a_shift_one_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && instr_o.op == mdd_pkg::OP_SHIFT_ONE && !instr_o.mem)
    |-> run_len_r == `MDD_C_SHIFT1_R) else $error("shift by one length");

endmodule : mdd_decode
